/* shared/sync_fifo_pkg.sv */
// Constants for the sync and FIFO alignment status block.
// Assumes a byte-wide register port at the documented offsets.
package sync_fifo_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_SYNC_MODE_CTRL  = 8'h10;
    localparam logic [7:0] ADDR_SYNC_PHASE_REQ  = 8'h11;
    localparam logic [7:0] ADDR_SYNC_LOCK_STATE = 8'h12;
    localparam logic [7:0] ADDR_SYNC_PHASE_MEAS = 8'h13;
    localparam logic [7:0] ADDR_LEVEL_FAULTS    = 8'h15;
    localparam logic [7:0] ADDR_FIFO_OFS_CTRL   = 8'h17;
    localparam logic [7:0] ADDR_FIFO_ALIGN      = 8'h18;
    localparam logic [7:0] ADDR_FIFO_LEVEL      = 8'h19;
    // Reset values
    localparam logic [7:0] RST_SYNC_MODE_CTRL = 8'h08;
    localparam logic [5:0] RST_PHASE_REQ      = 6'h00;
    localparam logic [2:0] RST_FIFO_OFS       = 3'h0;
    // Sync mode control fields
    localparam int SYNC_EN_BIT    = 7;
    localparam int SYNC_RATE_BIT  = 6;
    localparam int SYNC_EDGE_BIT  = 3;
    localparam int SYNC_AVG_MSB   = 2;
    // Status bit positions
    localparam int LOST_BIT       = 7;
    localparam int LOCKED_BIT     = 6;
    localparam int WARN1_BIT      = 7;
    localparam int WARN2_BIT      = 6;
    localparam int SOFT_ACK_BIT   = 2;
    localparam int SOFT_REQ_BIT   = 1;
    localparam int HW_ALIGN_BIT   = 0;
    // Widths
    localparam int PHASE_W        = 6;
    localparam int PTR_W          = 3;
    localparam int FAULT_W        = 6;
    localparam int AVG_SUM_W      = 13;
    localparam int SAMPLE_CNT_W   = 8;
    // Warning windows, in pointer positions
    localparam logic [2:0] WARN1_SPAN = 3'h1;
    localparam logic [2:0] WARN2_SPAN = 3'h2;
endpackage

/* verilog/sync_fifo_status.sv */
// Sync phase control/status and input FIFO alignment/status logic.
// Assumes clk is the converter sample clock, input_data_clock the link
// clock from the data source, and level comparators on the pin receivers.
// Summary of operation
// - Hold six-bit requested sync phase offset, zero to sixty-three cycles.
// - Requested offset shifts the output frame marker relative to sync.
// - Lost flag, status bit 7, set when lock existed and was lost.
// - Locked flag, status bit 6, set once synchronization is attained.
// - Averaged measured phase read back as unsigned 6.2 fixed point.
// - Six fault flags: high and low level on frame, clock, data.
// - FIFO reset puts write pointer ahead of read by three-bit offset.
// - Warning bit 7 when pointers are within one position.
// - Warning bit 6 when pointers are within two positions.
// - Writing soft align request bit 1 makes the device reset the FIFO.
// - Acknowledge bit 2 set once soft requested alignment is done.
// - Bit 0 set once pointers aligned after hardware reset.
// - FIFO occupancy reported as eight-bit thermometer code.
// - Sync logic runs only while sync enable is set.
// - Rate select chooses FIFO reset rate or data rate for sync.
// - Edge select one uses rising sync edge, zero falling edge.
// - Phase averaged over two to the power of a three-bit field.
`timescale 1ns/100ps
module sync_fifo_status #(
    parameter int DATA_W = 32,                 // Sample lane width
    parameter int DEPTH  = 8                   // FIFO entries
) (
    input  wire logic              clk,              // Sample clock
    input  wire logic              srst,             // Sync reset, high
    input  wire logic              input_data_clock, // Link clock
    input  wire logic [DATA_W-1:0] sample_data_lanes,// Link data
    input  wire logic              sync_in,          // Async sync pin
    input  wire logic [5:0]        level_fault_in,   // Async comparators
    input  wire logic              sample_take,      // Pop one word
    input  wire logic [7:0]        reg_addr,         // Register address
    input  wire logic [7:0]        reg_wdata,        // Write data
    input  wire logic              reg_wr,           // Write strobe
    input  wire logic              reg_rd,           // Read strobe
    output logic [7:0]             reg_rdata,        // Read data
    output logic [DATA_W-1:0]      sample_out,       // FIFO output word
    output logic                   frame_marker      // Shifted frame tick
);
    localparam int PW = sync_fifo_pkg::PTR_W;
    localparam int AW = sync_fifo_pkg::SAMPLE_CNT_W;

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--)
            b[i] = b[i+1] ^ g[i];
        return b;
    endfunction

    // Link domain: reset crossing and write pointer
    logic [1:0]          link_rst_sync;
    logic [PW-1:0]       wr_bin;
    logic [PW-1:0]       wr_gray;
    logic [DATA_W-1:0]   mem [DEPTH];

    always_ff @(posedge input_data_clock)
    begin
        link_rst_sync <= {link_rst_sync[0], srst};
    end

    // Writer never stalls; overrun is what the warnings flag
    always_ff @(posedge input_data_clock)
    begin
        if (link_rst_sync[1])
        begin
            wr_bin  <= '0;
            wr_gray <= '0;
        end
        else
        begin
            mem[wr_bin] <= sample_data_lanes;
            wr_bin      <= wr_bin + 1'b1;
            wr_gray     <= (wr_bin + 1'b1) ^ ((wr_bin + 1'b1) >> 1);
        end
    end

    // Sample clock domain: synchronisers
    logic [PW-1:0]  wr_gray_s1, wr_gray_s2;
    logic [1:0]     sync_pin_sync;
    logic           sync_prev;
    logic [5:0]     fault_s1, fault_s2;

    always_ff @(posedge clk)
    begin
        wr_gray_s1    <= wr_gray;
        wr_gray_s2    <= wr_gray_s1;
        sync_pin_sync <= {sync_pin_sync[0], sync_in};
        sync_prev     <= sync_pin_sync[1];
        fault_s1      <= level_fault_in;
        fault_s2      <= fault_s1;
    end

    // Control registers
    logic [7:0]     mode_ctrl;
    logic [5:0]     phase_req;
    logic [2:0]     fifo_ofs;
    logic           soft_req, soft_ack, hw_aligned, hw_pending;
    wire            wr_mode  = reg_wr
        && reg_addr == sync_fifo_pkg::ADDR_SYNC_MODE_CTRL;
    wire            wr_req   = reg_wr
        && reg_addr == sync_fifo_pkg::ADDR_SYNC_PHASE_REQ;
    wire            wr_ofs   = reg_wr
        && reg_addr == sync_fifo_pkg::ADDR_FIFO_OFS_CTRL;
    wire            wr_align = reg_wr
        && reg_addr == sync_fifo_pkg::ADDR_FIFO_ALIGN;
    wire            sync_en  = mode_ctrl[sync_fifo_pkg::SYNC_EN_BIT];
    wire            rate_dat = mode_ctrl[sync_fifo_pkg::SYNC_RATE_BIT];
    wire            edge_ris = mode_ctrl[sync_fifo_pkg::SYNC_EDGE_BIT];
    wire [2:0]      avg_sel  = mode_ctrl[sync_fifo_pkg::SYNC_AVG_MSB:0];

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mode_ctrl <= sync_fifo_pkg::RST_SYNC_MODE_CTRL;
            phase_req <= sync_fifo_pkg::RST_PHASE_REQ;
            fifo_ofs  <= sync_fifo_pkg::RST_FIFO_OFS;
        end
        else
        begin
            if (wr_mode)
                mode_ctrl <= reg_wdata;
            if (wr_req)
                phase_req <= reg_wdata[5:0];
            if (wr_ofs)
                fifo_ofs <= reg_wdata[2:0];
        end
    end

    // FIFO read side and alignment
    logic [PW-1:0]  rd_bin;
    wire  [PW-1:0]  wr_seen   = gray2bin(wr_gray_s2);
    wire  [PW-1:0]  ptr_diff  = wr_seen - rd_bin;
    wire  [PW-1:0]  ptr_back  = rd_bin - wr_seen;
    wire            soft_go   = soft_req;
    logic           sync_fifo_rst;
    wire            fifo_rst  = hw_pending || soft_go || sync_fifo_rst;
    wire            warn1     = ptr_diff <= sync_fifo_pkg::WARN1_SPAN
                             || ptr_back <= sync_fifo_pkg::WARN1_SPAN;
    wire            warn2     = ptr_diff <= sync_fifo_pkg::WARN2_SPAN
                             || ptr_back <= sync_fifo_pkg::WARN2_SPAN;
    logic [7:0]     therm;

    // Occupancy past 7 aliases onto small values; warnings cover that case
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            therm[i] = (i < int'(ptr_diff));
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rd_bin     <= '0;
            hw_pending <= 1'b1;
            hw_aligned <= 1'b0;
            soft_req   <= 1'b0;
            soft_ack   <= 1'b0;
            sample_out <= '0;
        end
        else
        begin
            if (fifo_rst)
                rd_bin <= wr_seen - fifo_ofs;
            else if (sample_take)
            begin
                sample_out <= mem[rd_bin];
                rd_bin     <= rd_bin + 1'b1;
            end
            hw_pending <= 1'b0;
            if (hw_pending)
                hw_aligned <= 1'b1;
            if (wr_align && reg_wdata[sync_fifo_pkg::SOFT_REQ_BIT])
            begin
                soft_req <= 1'b1;
                soft_ack <= 1'b0;
            end
            else if (soft_go)
            begin
                soft_req <= 1'b0;
                soft_ack <= 1'b1;
            end
        end
    end

    // Sync edge detection and phase measurement
    wire            edge_seen = edge_ris
                             ? (sync_pin_sync[1] && !sync_prev)
                             : (!sync_pin_sync[1] && sync_prev);
    logic           edge_pend;
    wire            rate_tick = rate_dat || rd_bin == '0;
    wire            sync_evt  = sync_en && (edge_seen || edge_pend)
                             && rate_tick;
    logic [5:0]     phase_cnt;
    logic [sync_fifo_pkg::AVG_SUM_W-1:0] phase_sum;
    logic [AW-1:0]  sample_cnt;
    logic [7:0]     phase_meas;
    logic           locked, lost, aligned;
    wire  [AW-1:0]  avg_len   = AW'(1) << avg_sel;
    wire            avg_done  = sync_evt && sample_cnt + 1'b1 == avg_len;
    wire  [sync_fifo_pkg::AVG_SUM_W-1:0] next_sum = phase_sum
                             + sync_fifo_pkg::AVG_SUM_W'(phase_cnt);
    wire  [sync_fifo_pkg::AVG_SUM_W+1:0] sum_x4 = {next_sum, 2'b00} >> avg_sel;
    wire  [7:0]     next_meas = sum_x4[7:0];
    wire            match     = next_meas == {phase_req, 2'b00};

    always_ff @(posedge clk)
    begin
        if (srst || !sync_en)
        begin
            edge_pend     <= 1'b0;
            phase_cnt     <= '0;
            phase_sum     <= '0;
            sample_cnt    <= '0;
            phase_meas    <= '0;
            locked        <= 1'b0;
            lost          <= 1'b0;
            aligned       <= 1'b0;
            sync_fifo_rst <= 1'b0;
            frame_marker  <= 1'b0;
        end
        else
        begin
            edge_pend     <= (edge_pend || edge_seen) && !rate_tick;
            phase_cnt     <= phase_cnt + 1'b1;
            frame_marker  <= phase_cnt == '1;
            sync_fifo_rst <= 1'b0;
            if (sync_evt && !aligned)
            begin
                // First edge realigns counter so later edges read the request
                phase_cnt     <= phase_req + 1'b1;
                aligned       <= 1'b1;
                sync_fifo_rst <= !rate_dat;
            end
            else if (sync_evt)
            begin
                phase_sum  <= avg_done ? '0 : next_sum;
                sample_cnt <= avg_done ? '0 : sample_cnt + 1'b1;
                if (avg_done)
                begin
                    phase_meas <= next_meas;
                    locked     <= match;
                    if (locked && !match)
                        lost <= 1'b1;
                end
            end
        end
    end

    // Register readback
    wire [7:0] lock_state  = {lost, locked, 6'h00};
    wire [7:0] align_state = {warn1, warn2, 3'h0, soft_ack, soft_req,
                              hw_aligned};
    wire [7:0] next_rdata  =
        reg_addr == sync_fifo_pkg::ADDR_SYNC_MODE_CTRL  ? mode_ctrl :
        reg_addr == sync_fifo_pkg::ADDR_SYNC_PHASE_REQ  ? {2'b00, phase_req} :
        reg_addr == sync_fifo_pkg::ADDR_SYNC_LOCK_STATE ? lock_state :
        reg_addr == sync_fifo_pkg::ADDR_SYNC_PHASE_MEAS ? phase_meas :
        reg_addr == sync_fifo_pkg::ADDR_LEVEL_FAULTS    ? {2'b00, fault_s2} :
        reg_addr == sync_fifo_pkg::ADDR_FIFO_OFS_CTRL   ? {5'h00, fifo_ofs} :
        reg_addr == sync_fifo_pkg::ADDR_FIFO_ALIGN      ? align_state :
        reg_addr == sync_fifo_pkg::ADDR_FIFO_LEVEL      ? therm : 8'h00;

    always_ff @(posedge clk)
    begin
        if (srst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    // Checks
    req_hold_a: assert property (@(posedge clk) disable iff (srst)
        !wr_req |=> phase_req == $past(phase_req))
        else $error("phase request changed without a write");
    // Cycles since the aligning edge; a delay cannot follow a register
    logic [6:0]     since_align;
    logic [5:0]     req_at_align;
    wire  [6:0]     marker_due = 7'(6'(6'h3E - req_at_align)) + 7'h02;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            since_align  <= '1;
            req_at_align <= '0;
        end
        else if (sync_evt && !aligned)
        begin
            since_align  <= 7'h01;
            req_at_align <= phase_req;
        end
        else if (since_align != '1)
            since_align <= since_align + 1'b1;
    end

    marker_a: assert property (@(posedge clk) disable iff (srst)
        sync_en && aligned && since_align == marker_due |-> frame_marker)
        else $error("frame marker not at requested offset");
    lost_a: assert property (@(posedge clk) disable iff (srst)
        $rose(lost) |-> $past(locked))
        else $error("lost set without prior lock");
    meas_a: assert property (@(posedge clk) disable iff (srst)
        $rose(locked) |-> phase_meas == {phase_req, 2'b00})
        else $error("lock without matching readback");
    fifo_rst_a: assert property (@(posedge clk) disable iff (srst)
        fifo_rst |=> wr_seen - rd_bin == $past(fifo_ofs)
                     || wr_seen != $past(wr_seen))
        else $error("pointer offset wrong after FIFO reset");
    warn_a: assert property (@(posedge clk) disable iff (srst)
        warn1 == (ptr_diff inside {3'h7, 3'h0, 3'h1})
        && warn2 == (ptr_diff inside {3'h6, 3'h7, 3'h0, 3'h1, 3'h2}))
        else $error("warning flags disagree with pointer gap");
    soft_a: assert property (@(posedge clk) disable iff (srst)
        wr_align && reg_wdata[sync_fifo_pkg::SOFT_REQ_BIT]
        |=> soft_req ##1 (soft_ack && !soft_req))
        else $error("soft align not acknowledged");
    hw_a: assert property (@(posedge clk)
        $fell(srst) |=> hw_aligned)
        else $error("hardware alignment flag not set");
    en_a: assert property (@(posedge clk) disable iff (srst)
        !sync_en |=> !locked && !lost)
        else $error("sync state held while disabled");
endmodule

/* test/link_source.sv */
// Link-side data source model for the sample interface.
// Assumes the bench gates the link clock with run between bursts.
`timescale 1ns/100ps
module link_source #(
    parameter int DATA_W = 32              // Sample lane width
) (
    input  wire logic         run,              // Link clock enable
    output logic              input_data_clock, // Link clock
    output logic [DATA_W-1:0] sample_data_lanes // Link data
);
    initial
    begin
        input_data_clock = 1'b0;
        sample_data_lanes = '0;
        #17;
        forever
        begin
            #62.5;
            // Parks low while stopped
            input_data_clock = run ? ~input_data_clock : 1'b0;
        end
    end
    // Data moves on the falling edge, clear of capture
    always @(negedge input_data_clock)
        sample_data_lanes <= sample_data_lanes + 1'b1;
endmodule

/* test/test_sync_fifo_status.sv */
// Self-checking bench for the sync and FIFO alignment status block.
// Assumes link_source on the link side and the byte register port.
`timescale 1ns/100ps
module test_sync_fifo_status;
    typedef struct {logic [2:0] ofs; logic [7:0] st; logic [7:0] lv;} row_t;
    logic        clk, srst, run, sync_in, sample_take, reg_wr, reg_rd;
    logic        input_data_clock, frame_marker;
    logic [31:0] sample_data_lanes, sample_out, word;
    logic [5:0]  level_fault_in;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
    int          failures, samples_checked, cyc, n;
    // Pointer gap k: warn1 at 0,1,7; warn2 at 0,1,2,6,7; ack set
    row_t rows [8] = '{'{3'h0, 8'hC4, 8'h00}, '{3'h1, 8'hC4, 8'h01},
        '{3'h2, 8'h44, 8'h03}, '{3'h3, 8'h04, 8'h07},
        '{3'h4, 8'h04, 8'h0F}, '{3'h5, 8'h04, 8'h1F},
        '{3'h6, 8'h44, 8'h3F}, '{3'h7, 8'hC4, 8'h7F}};

    link_source u_src (.run(run), .input_data_clock(input_data_clock),
        .sample_data_lanes(sample_data_lanes));
    sync_fifo_status u_dut (.clk(clk), .srst(srst),
        .input_data_clock(input_data_clock),
        .sample_data_lanes(sample_data_lanes), .sync_in(sync_in),
        .level_fault_in(level_fault_in), .sample_take(sample_take),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_out(sample_out),
        .frame_marker(frame_marker));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic chk(input string nm, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic results();
        if (failures == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic align(input logic [2:0] k);
        wr(sync_fifo_pkg::ADDR_FIFO_OFS_CTRL, {5'h00, k});
        wr(sync_fifo_pkg::ADDR_FIFO_ALIGN, 8'h02);
        repeat (4) @(posedge clk);
    endtask
    // Sync edge at a fixed phase of a 64-cycle grid
    task automatic edge_at(input int ph, input logic rise);
        for (n = 0; n < 70 && cyc % 64 != ph; n++) @(posedge clk);
        if (n >= 70)
        begin
            failures++;
            results();
        end
        sync_in <= rise;
        repeat (4) @(posedge clk);
        sync_in <= ~rise;
    endtask
    task automatic wait_mark();
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (frame_marker !== 1'b1 && n < 200);
        if (n >= 200)
        begin
            failures++;
            results();
        end
    endtask
    task automatic sync_run(input logic rise, input logic [2:0] avg);
        sync_in <= ~rise;
        wr(sync_fifo_pkg::ADDR_SYNC_PHASE_REQ, 8'h05);
        wr(sync_fifo_pkg::ADDR_SYNC_MODE_CTRL, {4'hC, rise, avg});
        repeat (3) edge_at(0, rise);
        repeat (10) @(posedge clk);
        rd(sync_fifo_pkg::ADDR_SYNC_LOCK_STATE, v);
        chk("locked", 8'h40, v & 8'hC0);
        rd(sync_fifo_pkg::ADDR_SYNC_PHASE_MEAS, v);
        chk("phase", 8'h14, v);
        wait_mark();
        wait_mark();
        chk("marker period", 8'h40, 8'(n));
        repeat (2) edge_at(3, rise);
        repeat (10) @(posedge clk);
        rd(sync_fifo_pkg::ADDR_SYNC_LOCK_STATE, v);
        chk("lost", 8'h80, v & 8'h80);
        wr(sync_fifo_pkg::ADDR_SYNC_MODE_CTRL, {4'h0, rise, 3'h0});
        edge_at(0, rise);
        rd(sync_fifo_pkg::ADDR_SYNC_LOCK_STATE, v);
        chk("sync off", 8'h00, v & 8'hC0);
    endtask

    initial
    begin
        {srst, run, sync_in, sample_take, reg_wr, reg_rd} = 6'b110000;
        {reg_addr, reg_wdata, level_fault_in} = '0;
        {failures, samples_checked, cyc} = '0;
        // Longer than 33 cycles so the link side sees 3 edges
        repeat (40) @(posedge clk);
        srst <= 1'b0;
        repeat (50) @(posedge clk);
        rd(sync_fifo_pkg::ADDR_SYNC_MODE_CTRL, v);
        chk("mode reset", 8'h08, v);
        rd(sync_fifo_pkg::ADDR_SYNC_PHASE_REQ, v);
        chk("phase req reset", 8'h00, v);
        rd(sync_fifo_pkg::ADDR_FIFO_OFS_CTRL, v);
        chk("offset reset", 8'h00, v);
        rd(sync_fifo_pkg::ADDR_FIFO_ALIGN, v);
        chk("hw aligned", 8'h01, v & 8'h01);
        wr(8'h14, 8'hFF);
        rd(8'h14, v);
        chk("unmapped", 8'h00, v);
        wr(sync_fifo_pkg::ADDR_SYNC_PHASE_REQ, 8'h3F);
        rd(sync_fifo_pkg::ADDR_SYNC_PHASE_REQ, v);
        chk("phase req max", 8'h3F, v);
        for (int i = 0; i < 6; i++)
        begin
            level_fault_in <= 6'(1 << i);
            repeat (4) @(posedge clk);
            rd(sync_fifo_pkg::ADDR_LEVEL_FAULTS, v);
            chk("level fault", 8'(1 << i), v);
        end
        level_fault_in <= 6'h00;
        // Frozen link clock keeps pointer gaps exact
        run <= 1'b0;
        repeat (30) @(posedge clk);
        foreach (rows[i])
        begin
            align(rows[i].ofs);
            rd(sync_fifo_pkg::ADDR_FIFO_ALIGN, v);
            chk("align status", rows[i].st, v & 8'hC6);
            rd(sync_fifo_pkg::ADDR_FIFO_LEVEL, v);
            chk("fill level", rows[i].lv, v);
        end
        align(3'h4);
        sample_take <= 1'b1;
        @(posedge clk);
        sample_take <= 1'b0;
        @(posedge clk);
        word = sample_out;
        repeat (3) @(posedge clk);
        rd(sync_fifo_pkg::ADDR_FIFO_LEVEL, v);
        chk("level after pop", 8'h07, v);
        @(posedge clk);
        sample_take <= 1'b1;
        @(posedge clk);
        sample_take <= 1'b0;
        @(posedge clk);
        chk("sample step", 8'h01, 8'(sample_out - word));
        run <= 1'b1;
        sync_run(1'b1, 3'h0);
        sync_run(1'b0, 3'h1);
        results();
    end
endmodule
